/* File: rtl/jtc_defines.vh */
// Constants for the test access port controller and instruction register.
//
// Contract
// - State changes on test-clock rise, by mode-select.
// - Sixteen states, six stable, ten transient.
// - Power-up in reset state; test logic idle.
// - Mode-select high five cycles forces reset.
// - Instruction resets to all ones, bypass.
// - Boundary-control resets to binary one-zero.
// - Boundary-control operation runs only in idle.
// - Select states do nothing, leave next cycle.
// - Capture-DR loads chosen register on exit edge; the boundary-control shift stage is not loaded and keeps its contents.
// - Shift entry drives output on falling edge.
// - Shift one bit per rise, including exit.
// - Exit1 falling edge returns output to high impedance.
// - Exit and pause keep contents, reshift allowed.
// - Update-DR latches shift stage on falling edge.
// - Capture-IR loads fixed status pattern.
// - Update-IR latches instruction on falling edge.
// - Eight-bit instruction, top bit ignored, no parity.
// - Unimplemented opcodes act as bypass.
// - Registers have shift stage plus latch; bypass not.
// - Exactly one register on the serial path.
// - Instruction sets mode, operation, register, capture source.
// - Sample on rising edge, drive on falling edge.
// - Bypass captures zero in Capture-DR.
// - Eighteen-bit boundary register, unchanged in reset.
`ifndef JTC_DEFINES_VH
`define JTC_DEFINES_VH

`define JTC_IR_WIDTH 8
`define JTC_IR_RESET 8'hFF
`define JTC_IR_STATUS 8'h81
`define JTC_BCR_WIDTH 2
`define JTC_BCR_RESET 2'h2
`define JTC_BSR_WIDTH 18
`define JTC_OPC_BYPASS 7'h01
`define JTC_OPC_EXTEST 7'h00
`define JTC_OPC_SAMPLE 7'h02
`define JTC_OPC_INTEST 7'h03
`define JTC_OPC_HIGHZ 7'h06
`define JTC_OPC_CLAMP 7'h07
`define JTC_OPC_RUNT 7'h09
`define JTC_OPC_READBN 7'h0A
`define JTC_OPC_READBT 7'h0B
`define JTC_OPC_CELLTST 7'h0C
`define JTC_OPC_TOPHIP 7'h0D
`define JTC_OPC_SCANCN 7'h0E
`define JTC_OPC_SCANCT 7'h0F
`define JTC_SEL_BYPASS 2'h0
`define JTC_SEL_BSR 2'h1
`define JTC_SEL_BCR 2'h2
`define JTC_FIFO_DEPTH 16
`define JTC_FIFO_AW 4

`endif

/* File: rtl/jtc_fifo.v */
// Holds no logic: the stream buffer module sits beside the port controller.

/* File: rtl/jtc_tap_controller.v */
// Test access port controller, test registers and the FIFO of the serial stream.
`include "jtc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module jtc_tap_controller (
  // System clock and reset
  input wire clk,
  input wire reset,
  // Test bus pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdoOe,
  // Captured boundary values and latched outputs
  input wire [`JTC_BSR_WIDTH-1:0] boundaryIn,
  output reg [`JTC_BSR_WIDTH-1:0] boundaryOut,
  output reg testMode,
  output reg bcrRun,
  output reg [`JTC_BCR_WIDTH-1:0] bcrOp,
  output reg [`JTC_IR_WIDTH-1:0] instruction,
  output reg [3:0] tapState,
  // Shifted-out bit stream
  output reg scanValid,
  input wire scanReady,
  output reg scanData
);
  // ---------------------------------------------------------------
  // State codes
  // ---------------------------------------------------------------
  localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004,
    S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020, S_PADR = 16'h0040,
    S_EX2DR = 16'h0080, S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400,
    S_SHIR = 16'h0800, S_EX1IR = 16'h1000, S_PAIR = 16'h2000, S_EX2IR = 16'h4000,
    S_UPIR = 16'h8000;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  reg tckPrev_r;
  wire [2:0] pinRaw;
  wire [2:0] pinSync;
  wire tckIn;
  wire tmsIn;
  wire tdiIn;
  wire tckRise;
  wire tckFall;
  genvar g;

  assign pinRaw = {tdi, tms, tck};
  assign tckIn = pinSync[0];
  assign tmsIn = pinSync[1];
  assign tdiIn = pinSync[2];

  // Each pin passes two flip-flops, both reset to the pulled-up idle level.
  generate
    for (g = 0; g < 3; g = g + 1) begin : gPin
      reg meta_r;
      reg sync_r;
      always @(posedge clk) begin
        if (reset) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= pinRaw[g];
          sync_r <= meta_r;
        end
      end
      assign pinSync[g] = sync_r;
    end
  endgenerate

  // The edge detector starts high as well, so no false rise follows reset.
  always @(posedge clk) begin
    if (reset) begin
      tckPrev_r <= 1'b1;
    end else begin
      tckPrev_r <= tckIn;
    end
  end

  // Test clock levels shorter than one system clock may lose an edge.
  assign tckRise = tckIn && !tckPrev_r;
  assign tckFall = !tckIn && tckPrev_r;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Data register selected by an instruction; unknown codes act as bypass.
  function [1:0] selectReg;
    input [`JTC_IR_WIDTH-1:0] ins;
    begin
      case (ins[6:0])
        `JTC_OPC_EXTEST, `JTC_OPC_SAMPLE, `JTC_OPC_INTEST, `JTC_OPC_READBN,
        `JTC_OPC_READBT, `JTC_OPC_CELLTST: selectReg = `JTC_SEL_BSR;
        `JTC_OPC_SCANCN, `JTC_OPC_SCANCT: selectReg = `JTC_SEL_BCR;
        default: selectReg = `JTC_SEL_BYPASS;
      endcase
    end
  endfunction

  // Test mode flag of an instruction.
  function isTest;
    input [`JTC_IR_WIDTH-1:0] ins;
    begin
      case (ins[6:0])
        `JTC_OPC_EXTEST, `JTC_OPC_INTEST, `JTC_OPC_HIGHZ, `JTC_OPC_CLAMP,
        `JTC_OPC_RUNT, `JTC_OPC_READBT, `JTC_OPC_TOPHIP,
        `JTC_OPC_SCANCT: isTest = 1'b1;
        default: isTest = 1'b0;
      endcase
    end
  endfunction

  // Encoded state number of a one-hot state.
  function [3:0] stateNum;
    input [15:0] s;
    integer i;
    begin
      stateNum = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (s[i]) begin
          stateNum = i[3:0];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Controller state machine
  // ---------------------------------------------------------------
  reg [15:0] state_r;
  reg [15:0] state_nxt;
  wire m;

  assign m = tmsIn;

  always @* begin
    case (state_r)
      S_RESET: state_nxt = m ? S_RESET : S_IDLE;
      S_IDLE: state_nxt = m ? S_SELDR : S_IDLE;
      S_SELDR: state_nxt = m ? S_SELIR : S_CAPDR;
      S_CAPDR: state_nxt = m ? S_EX1DR : S_SHDR;
      S_SHDR: state_nxt = m ? S_EX1DR : S_SHDR;
      S_EX1DR: state_nxt = m ? S_UPDR : S_PADR;
      S_PADR: state_nxt = m ? S_EX2DR : S_PADR;
      S_EX2DR: state_nxt = m ? S_UPDR : S_SHDR;
      S_UPDR: state_nxt = m ? S_SELDR : S_IDLE;
      S_SELIR: state_nxt = m ? S_RESET : S_CAPIR;
      S_CAPIR: state_nxt = m ? S_EX1IR : S_SHIR;
      S_SHIR: state_nxt = m ? S_EX1IR : S_SHIR;
      S_EX1IR: state_nxt = m ? S_UPIR : S_PAIR;
      S_PAIR: state_nxt = m ? S_EX2IR : S_PAIR;
      S_EX2IR: state_nxt = m ? S_UPIR : S_SHIR;
      S_UPIR: state_nxt = m ? S_SELDR : S_IDLE;
      default: state_nxt = S_RESET;
    endcase
  end

  // ---------------------------------------------------------------
  // Shift stages and latches
  // ---------------------------------------------------------------
  reg [`JTC_IR_WIDTH-1:0] irShift_r;
  reg [`JTC_BSR_WIDTH-1:0] bsrShift_r;
  reg [`JTC_BCR_WIDTH-1:0] bcrShift_r;
  reg bypass_r;
  wire [1:0] sel;
  wire inShift;
  reg serialBit;

  assign sel = selectReg(instruction);
  assign inShift = (state_r == S_SHDR) || (state_r == S_SHIR);

  // Exactly one register feeds the serial output.
  always @* begin
    if (state_r == S_SHIR) begin
      serialBit = irShift_r[0];
    end else begin
      case (sel)
        `JTC_SEL_BSR: serialBit = bsrShift_r[0];
        `JTC_SEL_BCR: serialBit = bcrShift_r[0];
        default: serialBit = bypass_r;
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_r <= S_RESET;
      irShift_r <= `JTC_IR_RESET;
      bsrShift_r <= {`JTC_BSR_WIDTH{1'b0}};
      bcrShift_r <= `JTC_BCR_RESET;
      bypass_r <= 1'b0;
    end else if (tckRise) begin
      state_r <= state_nxt;
      case (state_r)
        S_CAPIR: irShift_r <= `JTC_IR_STATUS;
        S_SHIR: irShift_r <= {tdiIn, irShift_r[`JTC_IR_WIDTH-1:1]};
        S_CAPDR: begin
          if (sel == `JTC_SEL_BSR) begin
            bsrShift_r <= boundaryIn;
          end else if (sel == `JTC_SEL_BYPASS) begin
            bypass_r <= 1'b0;
          end
        end
        S_SHDR: begin
          case (sel)
            `JTC_SEL_BSR: bsrShift_r <= {tdiIn, bsrShift_r[`JTC_BSR_WIDTH-1:1]};
            `JTC_SEL_BCR: bcrShift_r <= {tdiIn, bcrShift_r[1]};
            default: bypass_r <= tdiIn;
          endcase
        end
        default: bypass_r <= bypass_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Falling-edge outputs
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      instruction <= `JTC_IR_RESET;
      bcrOp <= `JTC_BCR_RESET;
      boundaryOut <= {`JTC_BSR_WIDTH{1'b0}};
      testMode <= 1'b0;
      tdo <= 1'b1;
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdoOe <= inShift;
      tdo <= inShift ? serialBit : 1'b1;
      if (state_r == S_RESET) begin
        instruction <= `JTC_IR_RESET;
        bcrOp <= `JTC_BCR_RESET;
        testMode <= 1'b0;
      end else if (state_r == S_UPIR) begin
        instruction <= irShift_r;
        testMode <= isTest(irShift_r);
      end else if (state_r == S_UPDR) begin
        if (sel == `JTC_SEL_BSR) begin
          boundaryOut <= bsrShift_r;
        end else if (sel == `JTC_SEL_BCR) begin
          bcrOp <= bcrShift_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Status and serial stream
  // ---------------------------------------------------------------
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoOutData;

  jtc_fifo #(
    .WIDTH(1),
    .DEPTH(`JTC_FIFO_DEPTH),
    .AW(`JTC_FIFO_AW)
  ) uFifo (
    .clk(clk),
    .reset(reset),
    .inValid(tckFall && inShift),
    .inReady(fifoInReady),
    .inData(serialBit),
    .outValid(fifoOutValid),
    .outReady(scanReady || !scanValid),
    .outData(fifoOutData)
  );

  always @(posedge clk) begin
    if (reset) begin
      tapState <= 4'h0;
      bcrRun <= 1'b0;
      scanValid <= 1'b0;
      scanData <= 1'b0;
    end else begin
      tapState <= stateNum(state_r);
      bcrRun <= (state_r == S_IDLE) && (instruction[6:0] == `JTC_OPC_RUNT);
      if (scanReady || !scanValid) begin
        scanValid <= fifoOutValid;
        scanData <= fifoOutData;
      end
    end
  end
endmodule

// ---------------------------------------------------------------
// Stream buffer
// ---------------------------------------------------------------
// Parameterised flip-flop FIFO with valid and ready on both sides.
module jtc_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem_r[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/jtc_tap_monitor.sv */
// Concurrent checks on the outputs of the test port controller.
`timescale 1ns/100ps
`default_nettype none
module jtc_tap_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Observed outputs
  input wire logic tdo,
  input wire logic tdoOe,
  input wire logic [17:0] boundaryOut,
  input wire logic testMode,
  input wire logic bcrRun,
  input wire logic [1:0] bcrOp,
  input wire logic [7:0] instruction,
  input wire logic [3:0] tapState,
  input wire logic scanValid,
  input wire logic scanReady,
  input wire logic scanData
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic expTest;
  assign expTest = instruction[6:0] inside {7'h00, 7'h03, 7'h06, 7'h07,
    7'h09, 7'h0B, 7'h0D, 7'h0F};
  a_reset_values: assert property ($fell(reset) |-> instruction == 8'hFF && bcrOp == 2'h2)
    else $error("bad reset values");
  a_oe_enable: assert property ($rose(tdoOe) |-> tapState == 4'h4 || tapState == 4'hB)
    else $error("output enabled outside shift");
  a_oe_release: assert property ($fell(tdoOe) |-> tapState == 4'h5 || tapState == 4'hC)
    else $error("output released outside exit");
  a_select_leaves: assert property (
    $changed(tapState) && tapState inside {4'h2, 4'h9} |-> ##[1:16] $changed(tapState))
    else $error("select state held");
  a_tlr_resets: assert property (
    $changed(tapState) && tapState == 4'h0 |-> ##[0:16] instruction == 8'hFF && bcrOp == 2'h2)
    else $error("reset state left registers");
  a_tlr_quiet: assert property (tapState == 4'h0 |-> !tdoOe && !bcrRun)
    else $error("test logic active in reset state");
  a_run_in_idle: assert property (
    $rose(bcrRun) |-> instruction[6:0] == 7'h09 ##[0:1] tapState == 4'h1)
    else $error("operation run outside idle");
  a_mode_decode: assert property ($stable(instruction) [*3] |-> testMode == expTest)
    else $error("mode does not match instruction");
  a_released_high: assert property (!tdoOe && !$past(tdoOe) |-> tdo)
    else $error("released output not high");
  a_boundary_kept: assert property (
    tapState == 4'h0 && $past(tapState) == 4'h0 |-> $stable(boundaryOut))
    else $error("boundary changed in reset state");
  a_scan_hold: assert property (scanValid && !scanReady |=> scanValid && $stable(scanData))
    else $error("stream bit dropped while stalled");
  cover property (bcrRun);
  cover property (tdoOe && tapState == 4'hB);
  cover property (scanValid && !scanReady);
endmodule
`default_nettype wire

/* File: bench/jtc_tester.sv */
// Behavioural test bus master driving clock, mode select and data in.
`timescale 1ns/100ps
`default_nettype none
module jtc_tester (
  // Test bus
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOe
);
  // A released output floats to its pull-up level.
  wire tdoLine = tdoOe ? tdo : 1'b1;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Levels change at the fall; the output is taken just before the rise.
  task automatic step(input logic m, input logic dv, output logic q);
    tck = 1'b0;
    tms = m;
    tdi = dv;
    #24 q = tdoLine;
    tck = 1'b1;
    #24;
  endtask
endmodule
`default_nettype wire

/* File: bench/jtc_tap_controller_tb.sv */
// Self-checking bench for the test port controller.
`timescale 1ns/100ps
`default_nettype none
module jtc_tap_controller_tb;
  logic clk, reset, tck, tms, tdi, tdo, tdoOe, testMode, bcrRun, scanValid, scanReady, scanData, b;
  logic [17:0] boundaryIn, boundaryOut, d;
  logic [1:0] bcrOp;
  logic [7:0] instruction;
  logic [3:0] tapState;
  int mismatches = 0, totalChecks = 0, cycles = 0, cnt = 0;
  jtc_tap_controller i_jtc_tap_controller (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .boundaryIn(boundaryIn), .boundaryOut(boundaryOut),
    .testMode(testMode), .bcrRun(bcrRun), .bcrOp(bcrOp), .instruction(instruction),
    .tapState(tapState), .scanValid(scanValid), .scanReady(scanReady), .scanData(scanData));
  jtc_tester i_jtc_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input logic m, input logic dv, output logic q);
    i_jtc_tester.step(m, dv, q);
  endtask
  // From idle, scans n bits through one path and returns to idle.
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
    output logic [17:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      giveVerdict();
    end
  end
  initial begin
    reset = 1'b1;
    boundaryIn = 18'h2A5C3;
    scanReady = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #1 check({instruction, bcrOp}, 10'h3FE);
    check({tdoOe, testMode, bcrRun, tapState}, 7'h00);
    step(1'b0, 1'b1, b);
    scan(1'b1, 8, 18'h8E, d);
    check(d, 18'h81);
    check({instruction, testMode}, 9'h11C);
    scan(1'b0, 2, 18'h1, d);
    check({d[1:0], bcrOp}, 4'h9);
    scan(1'b1, 8, 18'h09, d);
    check({bcrRun, testMode}, 2'h3);
    step(1'b1, 1'b1, b);
    check(bcrRun, 1'b0);
    step(1'b1, 1'b1, b);
    step(1'b1, 1'b1, b);
    step(1'b1, 1'b1, b);
    check({tapState, instruction, bcrOp}, 14'h03FE);
    step(1'b0, 1'b1, b);
    scan(1'b1, 8, 18'h04, d);
    scan(1'b0, 2, 18'h3, d);
    check({d[1:0], testMode}, 3'h4);
    scan(1'b1, 8, 18'h02, d);
    scanReady = 1'b0;
    scan(1'b0, 18, 18'h15A3C, d);
    check(d, 18'h2A5C3);
    check(boundaryOut, 18'h15A3C);
    scanReady = 1'b1;
    d = '0;
    repeat (40) begin
      if (scanValid === 1'b1) begin
        d[cnt] = scanData;
        cnt++;
      end
      @(posedge clk);
      #1;
    end
    check(cnt[17:0], 18'h11);
    check(d, 18'h0A5C3);
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b1, 1'b1, b);
    repeat (5) step(1'b1, 1'b1, b);
    check({tapState, instruction}, 12'h0FF);
    check(boundaryOut, 18'h352E1);
    giveVerdict();
  end
endmodule
bind jtc_tap_controller jtc_tap_monitor i_jtc_tap_monitor (.clk(clk), .reset(reset), .tdo(tdo),
  .tdoOe(tdoOe), .boundaryOut(boundaryOut), .testMode(testMode), .bcrRun(bcrRun), .bcrOp(bcrOp),
  .instruction(instruction), .tapState(tapState), .scanValid(scanValid), .scanReady(scanReady),
  .scanData(scanData));
`default_nettype wire
